//--- asc_pkg.sv
// Constants for the converter sequencing and configuration block
package asc_pkg;
  // Register port widths
  localparam int AW = 4;
  localparam int DW = 16;

  // Register indices on the plain register port
  localparam logic [3:0] OFS_CTRL2  = 4'h0;
  localparam logic [3:0] OFS_CLK    = 4'h1;
  localparam logic [3:0] OFS_DMA    = 4'h2;
  localparam logic [3:0] OFS_AUX    = 4'h3;
  localparam logic [3:0] OFS_PRI    = 4'h4;
  localparam logic [3:0] OFS_SCAN_H = 4'h5;
  localparam logic [3:0] OFS_SCAN_L = 4'h6;
  localparam logic [3:0] OFS_PIN_DIGITAL_MODE_BITS_H = 4'h7;
  localparam logic [3:0] OFS_PIN_DIGITAL_MODE_BITS_L = 4'h8;
  localparam logic [3:0] OFS_MODE   = 4'h9;

  // Reset value of every register
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Writable bits per register; the rest read as zero, except control register two bit 7, which reads the buffer half
  localparam logic [15:0] CTRL2_WMASK     = 16'hE73F;
  localparam logic [15:0] CLK_WMASK       = 16'h9FFF;
  localparam logic [15:0] AUX_WMASK       = 16'h0707;
  localparam logic [15:0] PRI_WMASK       = 16'h9F9F;
  localparam logic [15:0] PRI_SECOND_MASK = 16'h8F8F;

  // Control register two fields
  localparam int POS_REF_HI   = 15;
  localparam int POS_REF_LO   = 13;
  localparam int POS_SCAN_EN  = 10;
  localparam int POS_CHCNT_HI = 9;
  localparam int POS_CHCNT_LO = 8;
  localparam int POS_BUF_HALF = 7;
  localparam int POS_RATE_HI  = 5;
  localparam int POS_RATE_LO  = 2;
  localparam int POS_SPLIT    = 1;
  localparam int POS_ALT      = 0;

  // Clock timing register fields
  localparam int POS_RC      = 15;
  localparam int POS_SAMT_HI = 12;
  localparam int POS_SAMT_LO = 8;
  localparam int POS_DIV_HI  = 7;

  // Auxiliary and primary input select fields
  localparam int POS_NEG_B_HI  = 10;
  localparam int POS_NEG_B_LO  = 9;
  localparam int POS_POS_B     = 8;
  localparam int POS_NEG_A_HI  = 2;
  localparam int POS_NEG_A_LO  = 1;
  localparam int POS_POS_A     = 0;
  localparam int POS_PNEG_B    = 15;
  localparam int POS_PSEL_B_HI = 12;
  localparam int POS_PSEL_B_LO = 8;
  localparam int POS_PNEG_A    = 7;
  localparam int POS_PSEL_A_HI = 4;

  // Decodes
  localparam logic [1:0] AUX_NEG_HIGH = 2'h3;
  localparam logic [1:0] AUX_NEG_MID  = 2'h2;
  localparam logic [3:0] CHAN_ONE     = 4'h1;
  localparam logic [3:0] CHAN_TWO     = 4'h3;
  localparam logic [3:0] CHAN_FOUR    = 4'hF;
  localparam logic [4:0] SCAN_WRAP    = 5'h1F;
endpackage

//--- asc_clk_if.sv
// Link between the control block and its conversion clock divider
`timescale 1ns/100ps
interface asc_clk_if;
  logic [7:0] divisor;
  logic       use_rc;
  logic       tick;

  modport ctrl (output divisor, output use_rc, input tick);
  modport div  (input divisor, input use_rc, output tick);
endinterface

//--- asc_tad_div.sv
// Conversion clock divider running off the instruction clock
`timescale 1ns/100ps
module asc_tad_div (
  input wire logic clk,
  input wire logic reset,
  asc_clk_if.div   bus
);
  import asc_pkg::*;

  // Divider state
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } asc_div_s;

  asc_div_s s;
  asc_div_s next_s;

  // One tick every divisor plus one instruction cycles
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (bus.use_rc) begin
      next_s.cnt = 8'h00; // Internal clock in use, divisor ignored
    end else if (s.cnt >= bus.divisor) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.tick = s.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_rc_quiet: assert property (bus.use_rc |=> !s.tick)
    else $error("divider ticked with internal clock selected");
  chk_tick_period: assert property (s.tick |-> $past(s.cnt) >= $past(bus.divisor))
    else $error("divider ticked before divisor reached");
endmodule

//--- asc_seq_ctrl.sv
// Converter sequencing, input selection and pin configuration control
`timescale 1ns/100ps
module asc_seq_ctrl #(
  parameter bit SECOND_CONVERTER = 1'b0,
  parameter int PIN_COUNT        = 32
) (
  input  wire logic [asc_pkg::AW-1:0] ADDR,
  input  wire logic                   CLK,
  input  wire logic                   RESET,
  input  wire logic [asc_pkg::DW-1:0] WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [asc_pkg::DW-1:0] RDATA,
  input  wire logic                   SAMPLE_DONE,
  input  wire logic [15:0]            PEER_PIN_DIGITAL_MODE_BITS_LOW,
  output logic      [2:0]             REF_CONFIG,
  output logic      [3:0]             CHANNEL_ENABLE,
  output logic      [4:0]             CH0_POS_SEL,
  output logic                        CH0_NEG_AN1,
  output logic                        CH0_LOW_REF,
  output logic                        AUX_POS_AN3_5,
  output logic                        AUX_NEG_AN9_11,
  output logic                        AUX_NEG_AN6_8,
  output logic                        SAMPLE_SET_B,
  output logic                        SEQ_EVENT,
  output logic                        BUFFER_HALF,
  output logic      [7:0]             DMA_WORDS_PER_INPUT,
  output logic      [4:0]             AUTO_SAMPLE_TIME,
  output logic                        USE_RC_CLOCK,
  output logic                        CONV_CLK_TICK,
  output logic      [31:0]            PIN_DIGITAL
);
  import asc_pkg::*;

  // All registers and sequencing state
  typedef struct packed {
    logic [15:0] ctrl2;
    logic [15:0] clk_cfg;
    logic [2:0]  dma_len;
    logic [15:0] aux;
    logic [15:0] pri;
    logic [15:0] scan_h;
    logic [15:0] scan_l;
    logic [15:0] pin_digital_mode_bits_h;
    logic [15:0] pin_digital_mode_bits_l;
    logic        twelve_bit;
    logic [15:0] rdata;
    logic [4:0]  scan_ptr;
    logic        set_b;
    logic [3:0]  rate_cnt;
    logic        buf_half;
    logic        seq_event;
  } asc_state_s;

  asc_state_s  s;
  asc_state_s  next_s;
  logic [31:0] scan_mask;
  logic [31:0] present;
  logic [3:0]  rate;
  logic        scan_en;
  logic        split;
  logic        alt;
  logic        rate_hit;
  logic [4:0]  scan_step;
  logic [4:0]  scan_first;
  logic [4:0]  pos_raw;
  logic [15:0] ctrl2_eff;
  logic [15:0] aux_eff;
  logic [15:0] rd_val;
  logic [1:0]  aux_neg;
  asc_clk_if   clk_bus ();

  // Next included input after cur, wrapping; cur itself if none set
  function automatic logic [4:0] next_scan(input logic [31:0] mask, input logic [4:0] cur);
    logic [4:0] idx;
    logic       found;
    next_scan = cur;
    found = 1'b0;
    for (int i = 1; i <= 32; i++) begin
      idx = cur + 5'(i);
      if (!found && mask[idx]) begin
        next_scan = idx; // Cleared bits are skipped
        found = 1'b1;
      end
    end
  endfunction

  // Field views of the registers
  assign scan_mask  = {s.scan_h, s.scan_l};
  assign rate       = s.ctrl2[POS_RATE_HI:POS_RATE_LO];
  assign scan_en    = s.ctrl2[POS_SCAN_EN];
  assign split      = s.ctrl2[POS_SPLIT];
  assign alt        = s.ctrl2[POS_ALT];
  assign rate_hit   = SAMPLE_DONE && (s.rate_cnt >= rate); // Never misses a lowered rate
  assign scan_step  = next_scan(scan_mask, s.scan_ptr);
  assign scan_first = next_scan(scan_mask, SCAN_WRAP);

  // Inputs that physically exist on this part
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      present[i] = (i < PIN_COUNT);
    end
  end

  // Twelve-bit mode hides channel count and auxiliary selects
  always_comb begin
    ctrl2_eff = s.ctrl2;
    ctrl2_eff[POS_BUF_HALF] = s.buf_half;
    if (s.twelve_bit) begin
      ctrl2_eff[POS_CHCNT_HI:POS_CHCNT_LO] = 2'b00;
    end
    aux_eff = s.twelve_bit ? 16'h0000 : s.aux;
  end

  // Register read decode, unmapped indices read zero
  always_comb begin
    case (ADDR)
      OFS_CTRL2:  rd_val = ctrl2_eff;
      OFS_CLK:    rd_val = s.clk_cfg;
      OFS_DMA:    rd_val = {13'h0000, s.dma_len};
      OFS_AUX:    rd_val = aux_eff;
      OFS_PRI:    rd_val = s.pri;
      OFS_SCAN_H: rd_val = s.scan_h;
      OFS_SCAN_L: rd_val = s.scan_l;
      OFS_PIN_DIGITAL_MODE_BITS_H: rd_val = s.pin_digital_mode_bits_h;
      OFS_PIN_DIGITAL_MODE_BITS_L: rd_val = s.pin_digital_mode_bits_l;
      OFS_MODE:   rd_val = {15'h0000, s.twelve_bit};
      default:    rd_val = 16'h0000;
    endcase
  end

  // Register writes and sample sequencing
  always_comb begin
    next_s = s;
    next_s.seq_event = 1'b0;
    next_s.rdata = RD ? rd_val : 16'h0000;
    if (WR) begin
      case (ADDR)
        OFS_CTRL2:  next_s.ctrl2 = WDATA & CTRL2_WMASK;
        OFS_CLK:    next_s.clk_cfg = WDATA & CLK_WMASK;
        OFS_DMA:    next_s.dma_len = WDATA[2:0];
        OFS_AUX:    next_s.aux = WDATA & AUX_WMASK;
        OFS_PRI:    next_s.pri = WDATA & (SECOND_CONVERTER ? PRI_SECOND_MASK : PRI_WMASK);
        OFS_SCAN_H: next_s.scan_h = WDATA; // Writable on every part
        OFS_SCAN_L: next_s.scan_l = WDATA;
        OFS_PIN_DIGITAL_MODE_BITS_H: begin
          if (!SECOND_CONVERTER) begin
            next_s.pin_digital_mode_bits_h = WDATA;
          end
        end
        OFS_PIN_DIGITAL_MODE_BITS_L: next_s.pin_digital_mode_bits_l = WDATA;
        OFS_MODE:   next_s.twelve_bit = WDATA[0];
        default:    next_s.rdata = next_s.rdata;
      endcase
    end
    if (SAMPLE_DONE) begin
      if (!s.set_b && scan_en) begin
        next_s.scan_ptr = scan_step;
      end
      next_s.set_b = ~s.set_b;
      if (rate_hit) begin
        next_s.rate_cnt = 4'h0;
        next_s.seq_event = 1'b1;
        next_s.buf_half = ~s.buf_half;
      end else begin
        next_s.rate_cnt = s.rate_cnt + 4'h1;
      end
    end
    // Scan restarts at the lowest included input while disabled
    if (!scan_en) begin
      next_s.scan_ptr = scan_first;
    end
    // Whole-buffer mode always refills from the start
    if (!split) begin
      next_s.buf_half = 1'b0;
    end
    if (!alt) begin
      next_s.set_b = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Conversion clock divider
  assign clk_bus.divisor = s.clk_cfg[POS_DIV_HI:0];
  assign clk_bus.use_rc  = s.clk_cfg[POS_RC];

  asc_tad_div u_div (
    .clk   (CLK),
    .reset (RESET),
    .bus   (clk_bus)
  );

  // Positive input of sample channel zero
  assign pos_raw = s.set_b ? s.pri[POS_PSEL_B_HI:POS_PSEL_B_LO]
                 : (scan_en ? s.scan_ptr : s.pri[POS_PSEL_A_HI:0]);
  assign aux_neg = s.set_b ? aux_eff[POS_NEG_B_HI:POS_NEG_B_LO]
                 : aux_eff[POS_NEG_A_HI:POS_NEG_A_LO];

  // Channel count decode
  always_comb begin
    if (ctrl2_eff[POS_CHCNT_HI]) begin
      CHANNEL_ENABLE = CHAN_FOUR;
    end else if (ctrl2_eff[POS_CHCNT_LO]) begin
      CHANNEL_ENABLE = CHAN_TWO;
    end else begin
      CHANNEL_ENABLE = CHAN_ONE;
    end
  end

  // Outputs toward the converter core and pins
  assign RDATA               = s.rdata;
  assign REF_CONFIG          = s.ctrl2[POS_REF_HI:POS_REF_LO];
  assign CH0_POS_SEL         = SECOND_CONVERTER ? {1'b0, pos_raw[3:0]} : pos_raw;
  assign CH0_LOW_REF         = !present[pos_raw] || (SECOND_CONVERTER && pos_raw[4]);
  assign CH0_NEG_AN1         = s.set_b ? s.pri[POS_PNEG_B] : s.pri[POS_PNEG_A];
  assign AUX_POS_AN3_5       = s.set_b ? aux_eff[POS_POS_B] : aux_eff[POS_POS_A];
  assign AUX_NEG_AN9_11      = (aux_neg == AUX_NEG_HIGH);
  assign AUX_NEG_AN6_8       = (aux_neg == AUX_NEG_MID);
  assign SAMPLE_SET_B        = s.set_b;
  assign SEQ_EVENT           = s.seq_event;
  assign BUFFER_HALF         = s.buf_half;
  assign DMA_WORDS_PER_INPUT = 8'h01 << s.dma_len;
  assign AUTO_SAMPLE_TIME    = s.clk_cfg[POS_SAMT_HI:POS_SAMT_LO];
  assign USE_RC_CLOCK        = s.clk_cfg[POS_RC];
  assign CONV_CLK_TICK       = clk_bus.tick;
  // Either converter's low bits switch a shared pin to digital
  assign PIN_DIGITAL = {(SECOND_CONVERTER ? 16'h0000 : s.pin_digital_mode_bits_h), s.pin_digital_mode_bits_l | PEER_PIN_DIGITAL_MODE_BITS_LOW}
                     & present;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_rate_event: assert property (rate_hit |=> SEQ_EVENT && s.rate_cnt == 4'h0)
    else $error("event missing after rate count");
  chk_rate_quiet: assert property (!SAMPLE_DONE |=> !SEQ_EVENT)
    else $error("event without a completed conversion");
  chk_chan_count: assert property (!s.twelve_bit && s.ctrl2[POS_CHCNT_HI]
                                   |-> CHANNEL_ENABLE == CHAN_FOUR)
    else $error("channel count code not honoured");
  chk_twelve_hide: assert property (RD && ADDR == OFS_AUX && s.twelve_bit
                                    |=> RDATA == 16'h0000)
    else $error("aux selects visible in twelve-bit mode");
  chk_split_toggle: assert property (rate_hit && split && !WR
                                     |=> BUFFER_HALF != $past(BUFFER_HALF))
    else $error("buffer half did not alternate");
  chk_half_fixed: assert property (!split |=> !BUFFER_HALF)
    else $error("buffer half moved outside split mode");
  chk_scan_step: assert property (SAMPLE_DONE && !s.set_b && scan_en && !WR
                                  |=> s.scan_ptr == $past(scan_step))
    else $error("scan pointer did not step");
  chk_alt_sets: assert property (SAMPLE_DONE && alt && !WR
                                 |=> SAMPLE_SET_B != $past(SAMPLE_SET_B))
    else $error("sample set did not alternate");
  chk_dma_words: assert property (s.dma_len == 3'h7 |-> DMA_WORDS_PER_INPUT == 8'h80)
    else $error("largest buffer length wrong");
  chk_second_pins: assert property (SECOND_CONVERTER |-> !CH0_POS_SEL[4]
                                    && PIN_DIGITAL[31:16] == 16'h0000)
    else $error("second converter reaches upper inputs");
  chk_peer_pins: assert property (PEER_PIN_DIGITAL_MODE_BITS_LOW[0] && present[0] |-> PIN_DIGITAL[0])
    else $error("peer pin setting ignored");

  // Divider must stay quiet once the internal clock takes over
  chk_rc_ignore: assert property (USE_RC_CLOCK |=> !CONV_CLK_TICK)
    else $error("divided tick with internal clock selected");
  chk_chan_one: assert property (ctrl2_eff[POS_CHCNT_HI:POS_CHCNT_LO] == 2'b00
                                 |-> CHANNEL_ENABLE == CHAN_ONE)
    else $error("single channel code not honoured");
  chk_twelve_count: assert property (s.twelve_bit |-> CHANNEL_ENABLE == CHAN_ONE)
    else $error("channel count acts in twelve-bit mode");
  chk_words_min: assert property (s.dma_len == 3'h0 |-> DMA_WORDS_PER_INPUT == 8'h01)
    else $error("smallest buffer length wrong");

  // Input selection seen by the converter while set A is active, and the set B positive select
  chk_aux_neg_high: assert property (!s.twelve_bit && !s.set_b && s.aux[2:1] == 2'b11
                                     |-> AUX_NEG_AN9_11 && !AUX_NEG_AN6_8)
    else $error("aux negative high code not honoured");
  chk_aux_neg_ref: assert property (!s.set_b && !s.aux[2]
                                    |-> !AUX_NEG_AN9_11 && !AUX_NEG_AN6_8)
    else $error("aux negative reference code not honoured");
  chk_aux_pos_a: assert property (!s.twelve_bit && !s.set_b
                                  |-> AUX_POS_AN3_5 == s.aux[POS_POS_A])
    else $error("aux positive select not honoured");
  chk_pri_neg_a: assert property (!s.set_b |-> CH0_NEG_AN1 == s.pri[POS_PNEG_A])
    else $error("primary negative select not honoured");
  chk_pri_pos_b: assert property (s.set_b
                                  |-> CH0_POS_SEL == s.pri[POS_PSEL_B_HI:POS_PSEL_B_LO])
    else $error("set B positive select not honoured");

  // Missing inputs never reach the converter as real pins; own low pin bits on present pins take effect
  chk_low_ref: assert property (!present[CH0_POS_SEL] |-> CH0_LOW_REF)
    else $error("missing input not tied to low reference");
  chk_pin_absent: assert property ((PIN_DIGITAL & ~present) == 32'h00000000)
    else $error("pin bit without a pin has effect");
  chk_pin_own: assert property (((s.pin_digital_mode_bits_l & present[15:0]) & ~PIN_DIGITAL[15:0])
                                == 16'h0000)
    else $error("own pin digital bit ignored");

  cov_event:  cover property (SEQ_EVENT ##1 SEQ_EVENT);
  cov_scan:   cover property (scan_en && SAMPLE_DONE ##1 s.scan_ptr != $past(s.scan_ptr));
  cov_alt:    cover property (alt && SAMPLE_DONE ##1 SAMPLE_SET_B);
  cov_split:  cover property (split && SEQ_EVENT && BUFFER_HALF);
  cov_rc:     cover property (USE_RC_CLOCK ##1 !USE_RC_CLOCK);
endmodule

//--- asc_conv_model.sv
// Behavioural converter core that reports completed samples
`timescale 1ns/100ps
module asc_conv_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [7:0] count,
  input  wire logic [3:0] gap,
  output logic            done,
  output logic            busy
);
  logic [7:0] left;
  logic [3:0] wait_c;

  // One done pulse per finished conversion, gap idle cycles between
  always @(posedge clk) begin
    if (reset) begin
      left <= 8'h00;
      wait_c <= 4'h0;
      done <= 1'b0;
    end else if (start) begin
      left <= count;
      wait_c <= 4'h0;
      done <= 1'b0;
    end else if (left != 8'h00 && wait_c == 4'h0) begin
      done <= 1'b1;
      left <= left - 8'h01;
      wait_c <= gap;
    end else begin
      done <= 1'b0;
      if (wait_c != 4'h0) wait_c <= wait_c - 4'h1;
    end
  end

  // Busy until the last pulse has gone, so the bench can wait on it
  assign busy = (left != 8'h00) || done;
endmodule

//--- tb_asc.sv
// Self-checking bench for the converter sequencing control block
`timescale 1ns/100ps
module tb;
  import asc_pkg::*;
  localparam int PINS = 24; // Fewer pins than inputs, so missing pins show
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic [DW-1:0] v;
  logic [15:0]   peer;
  logic [7:0]    cnt;
  logic [3:0]    gap;
  logic [2:0]    ref_cfg;
  logic [3:0]    ch_en;
  logic [4:0]    pos_sel;
  logic [4:0]    samt;
  logic [7:0]    words;
  logic [31:0]   pin_dig;
  logic          clk, reset, wr, rd, start, done, busy, neg1, low_ref;
  logic          aux_pos, aux_n9, aux_n6, set_b, seq_ev, half, use_rc, tick;
  int            n_mismatch, checks_done, ev, tk, cyc, k;
  logic [15:0]   msk [0:10] = '{16'hE73F, 16'h9FFF, 16'h0007, 16'h0707, 16'h9F9F,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000};
  logic [3:0]    ce [0:3] = '{4'h1, 4'h3, 4'hF, 4'hF};
  logic [7:0]    rates [0:2] = '{8'h00, 8'h03, 8'h0F};

  asc_seq_ctrl #(.SECOND_CONVERTER(1'b0), .PIN_COUNT(PINS)) DUT (
    .ADDR(addr), .CLK(clk), .RESET(reset), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SAMPLE_DONE(done), .PEER_PIN_DIGITAL_MODE_BITS_LOW(peer), .REF_CONFIG(ref_cfg),
    .CHANNEL_ENABLE(ch_en), .CH0_POS_SEL(pos_sel), .CH0_NEG_AN1(neg1),
    .CH0_LOW_REF(low_ref), .AUX_POS_AN3_5(aux_pos), .AUX_NEG_AN9_11(aux_n9),
    .AUX_NEG_AN6_8(aux_n6), .SAMPLE_SET_B(set_b), .SEQ_EVENT(seq_ev),
    .BUFFER_HALF(half), .DMA_WORDS_PER_INPUT(words), .AUTO_SAMPLE_TIME(samt),
    .USE_RC_CLOCK(use_rc), .CONV_CLK_TICK(tick), .PIN_DIGITAL(pin_dig));

  asc_conv_model conv (.clk(clk), .reset(reset), .start(start), .count(cnt),
    .gap(gap), .done(done), .busy(busy));

  // 200 MHz clock; events, ticks and a hang guard counted on it
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (seq_ev === 1'b1) ev++;
    if (tick === 1'b1) tk++;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle write; outputs settle one cycle later
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {16'h0000, e}, {16'h0000, rdata});
  endtask

  // Ask the converter model for n back-to-back completions
  task automatic run_done(input logic [7:0] n);
    @(posedge clk);
    start <= 1'b1;
    cnt <= n;
    @(posedge clk);
    start <= 1'b0;
    #1;
    k = 0;
    while (busy && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    start = 1'b0;
    cnt = 8'h00;
    gap = 4'h0;
    peer = 16'h0000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // Reset state of indices 0 to 10, one unmapped index included
    for (int i = 0; i < 11; i++) rd_chk(i[3:0], 16'h0000);
    chk("chan_en", 32'h1, ch_en);
    chk("words", 32'h1, words);
    // Writable bits per register; mode last so nothing is hidden early
    for (int i = 0; i < 11; i++) begin
      wr_reg(i[3:0], 16'hFFFF);
      rd_chk(i[3:0], msk[i]);
    end
    rd_chk(OFS_CTRL2, 16'hE43F);
    rd_chk(OFS_AUX, 16'h0000);
    chk("chan_en_12b", 32'h1, ch_en);
    for (int i = 0; i < 10; i++) wr_reg(i[3:0], 16'h0000);
    // Channel count codes and reference code
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFS_CTRL2, {6'h00, c[1:0], 8'h00});
      chk("chan_en", {28'h0, ce[c]}, ch_en);
    end
    wr_reg(OFS_CTRL2, 16'hA000);
    chk("ref", 32'h5, ref_cfg);
    for (int n = 0; n < 8; n++) begin
      wr_reg(OFS_DMA, {13'h0000, n[2:0]});
      chk("words", 32'h1 << n, words);
    end
    // Auxiliary input codes for set A
    for (int c = 0; c < 8; c++) begin
      wr_reg(OFS_AUX, {13'h0000, c[2:0]});
      chk("aux", {29'h0, c[0], c[2:1] == 2'h3, c[2:1] == 2'h2}, {aux_pos, aux_n9, aux_n6});
    end
    // Primary select, and an input beyond the last pin
    wr_reg(OFS_PRI, 16'h0085);
    chk("pri", 32'h016, {pos_sel, neg1, low_ref});
    wr_reg(OFS_PRI, 16'h001E);
    chk("pri_lowref", 32'h079, {pos_sel, neg1, low_ref});
    // Own and peer low pin bits merge; high bits past the last pin do nothing
    peer = 16'h0F00;
    wr_reg(OFS_PIN_DIGITAL_MODE_BITS_L, 16'h00F0);
    wr_reg(OFS_PIN_DIGITAL_MODE_BITS_H, 16'hFFFF);
    chk("pins", 32'h00FF0FF0, pin_dig);
    rd_chk(OFS_PIN_DIGITAL_MODE_BITS_H, 16'hFFFF);
    // Event rate with split buffer; sixteen back-to-back completions each
    for (int r = 0; r < 3; r++) begin
      wr_reg(OFS_CTRL2, {8'h00, rates[r][5:0], 2'h2});
      ev = 0;
      run_done(8'h10);
      chk("events", 32'h10 / (rates[r] + 1), ev);
    end
    chk("half", 32'h1, half);
    rd_chk(OFS_CTRL2, 16'h00BE);
    wr_reg(OFS_CTRL2, 16'h003C);
    rd_chk(OFS_CTRL2, 16'h003C);
    // Alternating sample sets
    wr_reg(OFS_PRI, 16'h0702);
    wr_reg(OFS_CTRL2, 16'h0001);
    run_done(8'h01);
    chk("alt_b", 32'h27, {set_b, pos_sel});
    run_done(8'h01);
    chk("alt_a", 32'h02, {set_b, pos_sel});
    // Scan over inputs 2 and 4, wrapping
    wr_reg(OFS_CTRL2, 16'h0000);
    wr_reg(OFS_SCAN_L, 16'h0014);
    wr_reg(OFS_CTRL2, 16'h0400);
    chk("scan0", 32'h2, pos_sel);
    run_done(8'h01);
    chk("scan1", 32'h4, pos_sel);
    run_done(8'h01);
    chk("scan2", 32'h2, pos_sel);
    // Divided conversion clock, then the internal clock ignores the divisor
    wr_reg(OFS_CLK, 16'h0503);
    chk("samt", 32'h05, {use_rc, samt});
    repeat (8) @(posedge clk);
    #1;
    tk = 0;
    repeat (40) @(posedge clk);
    #1;
    chk("ticks", 32'd10, tk);
    wr_reg(OFS_CLK, 16'h8503);
    repeat (4) @(posedge clk);
    #1;
    tk = 0;
    repeat (40) @(posedge clk);
    #1;
    chk("ticks_rc", 32'h20, {use_rc, tk[4:0]});
    give_verdict();
  end
endmodule
